// >>> hdl/nwg_regs.sv
// nvm write guard: register file, unlock sequence, write engine and code protect gating
//
// Behaviour
// - write enable latch is cleared by every reset, including power-up.
// - data eeprom write start is refused while the power-up timer runs.
// - start needs the enable latch set and the key sequence just before it.
// - code protect of data eeprom leaves internal reads and writes working.
// - code protect of data eeprom blocks every external eeprom access.
// - code protect of data eeprom also blocks external program memory writes.
// - program memory protect keeps internal access, blocks all external program memory access.
// - internal program writes into the protected region are suppressed.
// - unlock port has no storage; it reads as zero.
// - low data byte register sits at index 10ch.
// - low address byte register sits at index 10dh.
// - high data byte register at 10eh holds six bits, top two read zero.
// - data and address registers are not reset; unused bits read zero.
// - short program write clears the start bit after one cycle.
`timescale 1ns/1ps
module nwg_regs #(
    parameter int PWRT_CYCLES = nwg_pkg::PWRT_CYCLES
) (
    input wire logic clk_i, // system clock, 50 mhz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic por_i, // power-on reset indication from the supply monitor
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [11:0] adr_i, // wishbone byte address
    input wire logic [3:0] sel_i, // wishbone byte selects
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o, // wishbone acknowledge
    output logic irq_o, // interrupt request level
    output nwg_pkg::nwg_nvm_req_type nvm_req_o, // request to the arrays
    input wire logic [13:0] nvm_rdata_i, // array read data, one cycle after rd
    input wire logic nvm_done_i, // array reports end of a long write
    input wire logic cp_data_i, // config: data eeprom code protect
    input wire logic cp_pgm_i, // config: program memory code protect
    input wire logic [1:0] protect_region_field_i, // config: write-protect region
    input wire logic ext_rd_req_i, // external programmer read request pin
    input wire logic ext_wr_req_i, // external programmer write request pin
    input wire logic ext_pgm_i, // external programmer targets program memory
    output logic ext_rd_grant_o, // external read allowed
    output logic ext_wr_grant_o // external write allowed
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] flags_q;
    logic [7:0] enables_q;
    logic irq_q;
    logic [7:0] data_low_q;
    logic [7:0] addr_low_q;
    logic [5:0] data_high_q;
    logic [2:0] addr_high_q;
    logic pgm_sel_q;
    logic free_q;
    logic aborted_q;
    logic write_enable_latch_q;
    logic wr_q;
    logic rd_q;
    logic rd_cap_q;
    localparam int PWRT_W = nwg_pkg::PWRT_W;
    localparam logic [PWRT_W-1:0] PWRT_LOAD = PWRT_W'(PWRT_CYCLES);
    logic [PWRT_W-1:0] pwrt_q;
    logic por_s1_q;
    logic por_s2_q;
    logic [2:0] ext_s1_q;
    logic [2:0] ext_s2_q;
    logic ext_rd_q;
    logic ext_wr_q;
    nwg_pkg::nwg_lock_type lock_q;
    nwg_pkg::nwg_eng_type eng_q;
    nwg_pkg::nwg_nvm_req_type req_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode and command terms
    logic acc;
    logic wr_acc;
    logic [9:0] idx;
    logic [7:0] wb;
    logic ctl_wr;
    logic [10:0] full_addr;
    logic [10:0] prot_limit;
    logic prot_hit;
    logic pwrt_run;
    logic go;
    logic short_wr;
    logic rd_go;

    assign acc = cyc_i && stb_i && !ack_q;
    assign wr_acc = acc && we_i && sel_i[0];
    assign idx = adr_i[11:2];
    assign wb = dat_i[7:0];
    assign ctl_wr = wr_acc && (idx == nwg_pkg::IDX_CONTROL);
    assign full_addr = {addr_high_q, addr_low_q};
    assign pwrt_run = (pwrt_q != '0);

    // protected program region from the configuration field
    always_comb begin
        case (protect_region_field_i)
            2'b00: prot_limit = nwg_pkg::PROT_LIMIT_00;
            2'b01: prot_limit = nwg_pkg::PROT_LIMIT_01;
            2'b10: prot_limit = nwg_pkg::PROT_LIMIT_10;
            default: prot_limit = nwg_pkg::PROT_LIMIT_11;
        endcase
    end
    assign prot_hit = (full_addr < prot_limit);

    // start accepted only with latch, fresh key and no guard in the way
    // internal accesses never look at the code-protect bits
    assign go = ctl_wr && wb[nwg_pkg::CTL_WR] && !wr_q && !rd_q && write_enable_latch_q
        && wb[nwg_pkg::CTL_WRITE_ENABLE_LATCH] && (lock_q == nwg_pkg::LK_ARMED)
        && (eng_q == nwg_pkg::EN_IDLE)
        && !(!wb[nwg_pkg::CTL_PGM_SEL] && pwrt_run)
        && !(wb[nwg_pkg::CTL_PGM_SEL] && prot_hit);
    assign short_wr = wb[nwg_pkg::CTL_PGM_SEL] && !wb[nwg_pkg::CTL_FREE]
        && (addr_low_q[1:0] != nwg_pkg::BLOCK_LAST);
    assign rd_go = ctl_wr && wb[nwg_pkg::CTL_RD] && !rd_q && !wr_q
        && (eng_q == nwg_pkg::EN_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // wishbone answer: ack one cycle after the request, registered data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= acc;
            dat_q <= '0;
            if (acc && !we_i) begin
                case (idx)
                    nwg_pkg::IDX_IRQ_FLAGS: dat_q[7:0] <= flags_q;
                    nwg_pkg::IDX_IRQ_ENABLES: dat_q[7:0] <= enables_q;
                    nwg_pkg::IDX_DATA_LOW: dat_q[7:0] <= data_low_q;
                    nwg_pkg::IDX_ADDR_LOW: dat_q[7:0] <= addr_low_q;
                    nwg_pkg::IDX_DATA_HIGH: dat_q[5:0] <= data_high_q;
                    nwg_pkg::IDX_ADDR_HIGH: dat_q[2:0] <= addr_high_q;
                    nwg_pkg::IDX_CONTROL: dat_q[7:0] <= {pgm_sel_q, 2'b00, free_q,
                        aborted_q, write_enable_latch_q, wr_q, rd_q};
                    default: dat_q <= '0; // unlock port and unmapped read zero
                endcase
            end
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////////
    // data and address registers: no reset, keep value through all resets
    always_ff @(posedge clk_i) begin
        if (wr_acc && idx == nwg_pkg::IDX_DATA_LOW) begin
            data_low_q <= wb;
        end
        if (wr_acc && idx == nwg_pkg::IDX_ADDR_LOW) begin
            addr_low_q <= wb;
        end
        if (wr_acc && idx == nwg_pkg::IDX_DATA_HIGH) begin
            data_high_q <= wb[5:0];
        end
        if (wr_acc && idx == nwg_pkg::IDX_ADDR_HIGH) begin
            addr_high_q <= wb[2:0];
        end
        if (rd_cap_q && !rst_i) begin
            data_low_q <= nvm_rdata_i[7:0];
            data_high_q <= nvm_rdata_i[13:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-on indication synchroniser and power-up timer
    always_ff @(posedge clk_i) begin
        por_s1_q <= por_i;
        por_s2_q <= por_s1_q;
    end

    // timer reloads on any reset and while power-on is flagged, then counts down
    always_ff @(posedge clk_i) begin
        if (rst_i || por_s2_q) begin
            pwrt_q <= PWRT_LOAD;
        end else if (pwrt_run) begin
            pwrt_q <= pwrt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock key tracker: the port itself stores nothing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_q <= nwg_pkg::LK_IDLE;
        end else if (wr_acc) begin
            if (idx == nwg_pkg::IDX_UNLOCK) begin
                if (lock_q == nwg_pkg::LK_GOT_FIRST && wb == nwg_pkg::KEY_SECOND) begin
                    lock_q <= nwg_pkg::LK_ARMED;
                end else if (wb == nwg_pkg::KEY_FIRST) begin
                    lock_q <= nwg_pkg::LK_GOT_FIRST;
                end else begin
                    lock_q <= nwg_pkg::LK_IDLE;
                end
            end else begin
                lock_q <= nwg_pkg::LK_IDLE; // any other write spends the key
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register and write engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // a cut long write stays flagged over a held reset; power-on clears it
            aborted_q <= (eng_q != nwg_pkg::EN_IDLE) || (aborted_q && !por_s2_q);
            pgm_sel_q <= 1'b0;
            free_q <= 1'b0;
            write_enable_latch_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rd_cap_q <= 1'b0;
            eng_q <= nwg_pkg::EN_IDLE;
            req_q <= '0;
        end else begin
            req_q.wr <= 1'b0;
            req_q.rd <= 1'b0;
            rd_cap_q <= req_q.rd;
            if (ctl_wr) begin
                write_enable_latch_q <= wb[nwg_pkg::CTL_WRITE_ENABLE_LATCH];
                aborted_q <= wb[nwg_pkg::CTL_ABORTED];
                if (eng_q == nwg_pkg::EN_IDLE && !wr_q) begin
                    pgm_sel_q <= wb[nwg_pkg::CTL_PGM_SEL];
                    free_q <= wb[nwg_pkg::CTL_FREE];
                end
            end
            if (rd_go) begin
                rd_q <= 1'b1;
                req_q.rd <= 1'b1;
                req_q.pgm <= wb[nwg_pkg::CTL_PGM_SEL];
                req_q.addr <= full_addr;
            end else if (rd_cap_q) begin
                rd_q <= 1'b0;
            end
            case (eng_q)
                nwg_pkg::EN_IDLE: begin
                    if (go) begin
                        wr_q <= 1'b1;
                        req_q.wr <= 1'b1;
                        req_q.pgm <= wb[nwg_pkg::CTL_PGM_SEL];
                        req_q.erase <= wb[nwg_pkg::CTL_FREE];
                        req_q.addr <= full_addr;
                        req_q.data <= {data_high_q, data_low_q};
                        if (!short_wr) begin
                            eng_q <= nwg_pkg::EN_RUN;
                        end
                    end else if (wr_q) begin
                        wr_q <= 1'b0; // short write ends after one cycle
                    end
                end
                nwg_pkg::EN_RUN: begin
                    if (nvm_done_i) begin
                        eng_q <= nwg_pkg::EN_FINISH;
                    end
                end
                nwg_pkg::EN_FINISH: begin
                    wr_q <= 1'b0;
                    eng_q <= nwg_pkg::EN_IDLE;
                end
                default: eng_q <= nwg_pkg::EN_IDLE;
            endcase
        end
    end
    assign nvm_req_o = req_q;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt flags, enables and output; a set beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= nwg_pkg::IRQ_FLAGS_RST;
            enables_q <= nwg_pkg::IRQ_ENABLES_RST;
            irq_q <= 1'b0;
        end else begin
            if (wr_acc && idx == nwg_pkg::IDX_IRQ_FLAGS) begin
                flags_q[nwg_pkg::IRQ_DONE_BIT] <= flags_q[nwg_pkg::IRQ_DONE_BIT]
                    & ~wb[nwg_pkg::IRQ_DONE_BIT];
            end
            if (eng_q == nwg_pkg::EN_RUN && nvm_done_i) begin
                flags_q[nwg_pkg::IRQ_DONE_BIT] <= 1'b1;
            end
            if (wr_acc && idx == nwg_pkg::IDX_IRQ_ENABLES) begin
                enables_q[nwg_pkg::IRQ_DONE_BIT] <= wb[nwg_pkg::IRQ_DONE_BIT];
            end
            irq_q <= |(flags_q & enables_q);
        end
    end
    assign irq_o = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // external programmer path: pins synchronised, code protect gates grants
    always_ff @(posedge clk_i) begin
        ext_s1_q <= {ext_pgm_i, ext_wr_req_i, ext_rd_req_i};
        ext_s2_q <= ext_s1_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_rd_q <= 1'b0;
            ext_wr_q <= 1'b0;
        end else begin
            ext_rd_q <= ext_s2_q[0] && (ext_s2_q[2] ? !cp_pgm_i : !cp_data_i);
            ext_wr_q <= ext_s2_q[1]
                && (ext_s2_q[2] ? !(cp_pgm_i || cp_data_i) : !cp_data_i);
        end
    end
    assign ext_rd_grant_o = ext_rd_q;
    assign ext_wr_grant_o = ext_wr_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_key_armed;
        lock_q == nwg_pkg::LK_ARMED;
    endsequence
    sequence s_short_go;
        go && short_wr;
    endsequence

    AST_WRITE_ENABLE_LATCH_RESET: assert property (@(posedge clk_i) rst_i |=> !write_enable_latch_q)
        else $error("enable latch not cleared by reset");
    AST_PWRT_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_q.wr && !req_q.pgm) |-> $past(pwrt_q) == '0)
        else $error("eeprom write started under power-up timer");
    AST_START_KEY: assert property (@(posedge clk_i) disable iff (rst_i)
        go |-> s_key_armed and write_enable_latch_q)
        else $error("start taken without key or latch");
    AST_KEY_SPENT: assert property (@(posedge clk_i) disable iff (rst_i)
        go |=> lock_q == nwg_pkg::LK_IDLE)
        else $error("key stays armed after start");
    AST_EXT_EE: assert property (@(posedge clk_i) disable iff (rst_i)
        (cp_data_i && !ext_s2_q[2])[*2] |=> !ext_rd_q && !ext_wr_q)
        else $error("external eeprom access under protect");
    AST_EXT_PGM_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        ((cp_data_i || cp_pgm_i) && ext_s2_q[2]) |=> !ext_wr_q)
        else $error("external program write under protect");
    AST_PROT_REGION: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_q.wr && req_q.pgm) |-> req_q.addr >= $past(prot_limit))
        else $error("write into protected region");
    AST_SHORT_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        s_short_go |=> wr_q ##1 !wr_q)
        else $error("short write start bit not cleared after one cycle");
    AST_DATA_HIGH_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q |-> dat_q[31:8] == '0)
        else $error("unimplemented bits read nonzero");
    AST_DONE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        (eng_q == nwg_pkg::EN_RUN && nvm_done_i && enables_q[nwg_pkg::IRQ_DONE_BIT])
        |=> ##1 irq_q)
        else $error("done interrupt missing");
endmodule

// >>> hdl/nwg_pkg.sv
// package: register map, field positions, timing and carrier types of the nvm write guard
package nwg_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [9:0] IDX_IRQ_FLAGS = 10'h00d;
    localparam logic [9:0] IDX_IRQ_ENABLES = 10'h08d;
    localparam logic [9:0] IDX_DATA_LOW = 10'h10c;
    localparam logic [9:0] IDX_ADDR_LOW = 10'h10d;
    localparam logic [9:0] IDX_DATA_HIGH = 10'h10e;
    localparam logic [9:0] IDX_ADDR_HIGH = 10'h10f;
    localparam logic [9:0] IDX_CONTROL = 10'h18c;
    localparam logic [9:0] IDX_UNLOCK = 10'h18d;
    // nvm_control bit positions
    localparam int CTL_PGM_SEL = 7;
    localparam int CTL_FREE = 4;
    localparam int CTL_ABORTED = 3;
    localparam int CTL_WRITE_ENABLE_LATCH = 2;
    localparam int CTL_WR = 1;
    localparam int CTL_RD = 0;
    // irq flag and enable bit position
    localparam int IRQ_DONE_BIT = 4;
    // reset values
    localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
    localparam logic [7:0] IRQ_ENABLES_RST = 8'h00;
    // unlock key bytes
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // last word of a four-word program block
    localparam logic [1:0] BLOCK_LAST = 2'h3;
    // protect field: write-protected program words lie below this limit
    localparam logic [10:0] PROT_LIMIT_00 = 11'h400;
    localparam logic [10:0] PROT_LIMIT_01 = 11'h200;
    localparam logic [10:0] PROT_LIMIT_10 = 11'h100;
    localparam logic [10:0] PROT_LIMIT_11 = 11'h000;
    // power-up timer
    localparam int CLK_HZ = 50_000_000;
    localparam int PWRT_MS = 72;
    localparam int PWRT_CYCLES = PWRT_MS * (CLK_HZ / 1000);
    localparam int PWRT_W = 22;
    // key sequence tracker, gray along the usual path
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_GOT_FIRST = 2'b01,
        LK_ARMED = 2'b11
    } nwg_lock_type;
    // write engine, gray along the usual path
    typedef enum logic [1:0] {
        EN_IDLE = 2'b00,
        EN_RUN = 2'b01,
        EN_FINISH = 2'b11
    } nwg_eng_type;
    // request towards the nonvolatile arrays
    typedef struct packed {
        logic wr;
        logic rd;
        logic pgm;
        logic erase;
        logic [10:0] addr;
        logic [13:0] data;
    } nwg_nvm_req_type;
endpackage

// >>> bench/nwg_array_model.sv
// nvm array model: answers reads and reports the end of long writes
`timescale 1ns/1ps
module nwg_array_model #(
    parameter int DONE_DLY = 20
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire nwg_pkg::nwg_nvm_req_type req_i, // request from the guard
    output logic [13:0] rdata_o, // array read data
    output logic done_o // end of a long write
);
    nwg_pkg::nwg_nvm_req_type last_q; // request seen at the last write start
    int wr_count = 0; // write starts seen
    int wait_q = 0; // cycles left of a long write
    ////////////////////////////////////////////////////////////////
    // read data stands one cycle, then shows its inverse so stale data never matches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 14'h1555;
        end else if (req_i.rd) begin
            rdata_o <= 14'h2b3c ^ {3'h0, req_i.addr};
        end else begin
            rdata_o <= ~rdata_o;
        end
    end
    // long writes end after a delay with a one-cycle done pulse
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            wait_q <= 0;
        end else if (req_i.wr) begin
            wr_count <= wr_count + 1;
            last_q <= req_i;
            if (!req_i.pgm || req_i.erase || req_i.addr[1:0] == nwg_pkg::BLOCK_LAST) begin
                wait_q <= DONE_DLY;
            end
        end else if (wait_q == 1) begin
            done_o <= 1'b1;
            wait_q <= 0;
        end else if (wait_q > 1) begin
            wait_q <= wait_q - 1;
        end
    end
endmodule

// >>> bench/nwg_regs_tb.sv
// testbench of the nvm write guard: register access, key sequence and protection
`timescale 1ns/1ps
module nwg_regs_tb;
    logic clk_i, rst_i, por_i, cyc_i, stb_i, we_i, ack_o, irq_o, nvm_done_i;
    logic cp_data_i, cp_pgm_i, ext_rd_req_i, ext_wr_req_i, ext_pgm_i;
    logic ext_rd_grant_o, ext_wr_grant_o;
    logic [11:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [1:0] protect_region_field_i;
    logic [13:0] nvm_rdata_i;
    nwg_pkg::nwg_nvm_req_type nvm_req_o;
    int err_total = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    int n0;
    ////////////////////////////////////////////////////////////////
    // design with a short power-up timer, and the array model
    nwg_regs #(.PWRT_CYCLES(50)) uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .nvm_req_o(nvm_req_o),
        .nvm_rdata_i(nvm_rdata_i), .nvm_done_i(nvm_done_i), .cp_data_i(cp_data_i),
        .cp_pgm_i(cp_pgm_i), .protect_region_field_i(protect_region_field_i),
        .ext_rd_req_i(ext_rd_req_i), .ext_wr_req_i(ext_wr_req_i), .ext_pgm_i(ext_pgm_i),
        .ext_rd_grant_o(ext_rd_grant_o), .ext_wr_grant_o(ext_wr_grant_o));
    nwg_array_model m (.clk_i(clk_i), .rst_i(rst_i), .req_i(nvm_req_o),
        .rdata_o(nvm_rdata_i), .done_o(nvm_done_i));
    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt > 20000) begin
            err_total++;
            test_done();
        end
    end
    // verdict and end of run
    task automatic test_done();
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, g, e);
        end
    endtask
    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d,
        output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        r = dat_o;
        if (n >= 50) begin
            err_total++;
            test_done();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, idx, d, r);
    endtask
    task automatic rchk(input logic [9:0] idx, input logic [7:0] e);
        logic [31:0] r;
        wb(1'b0, idx, 8'h00, r);
        chk(r, {24'h0, e});
    endtask
    // key bytes followed by the start command
    task automatic go(input logic [7:0] ctl);
        wr(nwg_pkg::IDX_UNLOCK, nwg_pkg::KEY_FIRST);
        wr(nwg_pkg::IDX_UNLOCK, nwg_pkg::KEY_SECOND);
        wr(nwg_pkg::IDX_CONTROL, ctl);
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_i, por_i, cyc_i, stb_i, we_i} = 5'h18;
        {cp_data_i, cp_pgm_i, ext_rd_req_i, ext_wr_req_i, ext_pgm_i} = 5'h00;
        adr_i = 12'h000;
        sel_i = 4'h1;
        dat_i = 32'h0;
        protect_region_field_i = 2'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        // reset values, unmapped place; start refused under the timer
        rchk(nwg_pkg::IDX_CONTROL, 8'h00);
        rchk(nwg_pkg::IDX_IRQ_FLAGS, nwg_pkg::IRQ_FLAGS_RST);
        rchk(nwg_pkg::IDX_IRQ_ENABLES, nwg_pkg::IRQ_ENABLES_RST);
        rchk(10'h001, 8'h00);
        wr(nwg_pkg::IDX_CONTROL, 8'h04);
        go(8'h06);
        rchk(nwg_pkg::IDX_CONTROL, 8'h04);
        chk(m.wr_count, 0);
        repeat (60) @(posedge clk_i);
        // data and address registers
        wr(nwg_pkg::IDX_DATA_HIGH, 8'hff);
        rchk(nwg_pkg::IDX_DATA_HIGH, 8'h3f);
        wr(nwg_pkg::IDX_ADDR_HIGH, 8'hff);
        rchk(nwg_pkg::IDX_ADDR_HIGH, 8'h07);
        wr(nwg_pkg::IDX_ADDR_LOW, 8'h3c);
        rchk(nwg_pkg::IDX_ADDR_LOW, 8'h3c);
        wr(nwg_pkg::IDX_UNLOCK, 8'h5a);
        rchk(nwg_pkg::IDX_UNLOCK, 8'h00);
        // starts without key, with a broken key, with keys swapped, without latch
        wr(nwg_pkg::IDX_CONTROL, 8'h06);
        wr(nwg_pkg::IDX_UNLOCK, nwg_pkg::KEY_FIRST);
        wr(nwg_pkg::IDX_DATA_LOW, 8'h11);
        wr(nwg_pkg::IDX_UNLOCK, nwg_pkg::KEY_SECOND);
        wr(nwg_pkg::IDX_CONTROL, 8'h06);
        wr(nwg_pkg::IDX_UNLOCK, nwg_pkg::KEY_SECOND);
        wr(nwg_pkg::IDX_UNLOCK, nwg_pkg::KEY_FIRST);
        wr(nwg_pkg::IDX_CONTROL, 8'h06);
        rchk(nwg_pkg::IDX_CONTROL, 8'h04);
        wr(nwg_pkg::IDX_CONTROL, 8'h00);
        go(8'h02);
        rchk(nwg_pkg::IDX_CONTROL, 8'h00);
        chk(m.wr_count, 0);
        // eeprom write and read under data protect, with done interrupt
        cp_data_i <= 1'b1;
        wr(nwg_pkg::IDX_IRQ_ENABLES, 8'h10);
        wr(nwg_pkg::IDX_ADDR_HIGH, 8'h01);
        wr(nwg_pkg::IDX_ADDR_LOW, 8'h23);
        wr(nwg_pkg::IDX_DATA_LOW, 8'h5a);
        wr(nwg_pkg::IDX_DATA_HIGH, 8'h15);
        rchk(nwg_pkg::IDX_DATA_LOW, 8'h5a);
        wr(nwg_pkg::IDX_CONTROL, 8'h04);
        go(8'h06);
        chk(m.wr_count, 1);
        chk({18'h0, m.last_q.pgm, m.last_q.addr, 2'h0}, 32'h48c);
        chk({18'h0, m.last_q.data}, 32'h155a);
        for (int k = 0; k < 100; k++) begin
            wb(1'b0, nwg_pkg::IDX_CONTROL, 8'h00, q);
            if (q[1] === 1'b0) break;
        end
        rchk(nwg_pkg::IDX_IRQ_FLAGS, 8'h10);
        chk({31'h0, irq_o}, 32'h1);
        wr(nwg_pkg::IDX_IRQ_ENABLES, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wr(nwg_pkg::IDX_IRQ_FLAGS, 8'h10);
        rchk(nwg_pkg::IDX_IRQ_FLAGS, 8'h00);
        wr(nwg_pkg::IDX_CONTROL, 8'h05);
        rchk(nwg_pkg::IDX_DATA_LOW, 8'h1f);
        rchk(nwg_pkg::IDX_DATA_HIGH, 8'h2a);
        cp_data_i <= 1'b0;
        // short program writes near the protected region, every region setting
        wr(nwg_pkg::IDX_ADDR_LOW, 8'hfe);
        n0 = m.wr_count;
        for (int i = 0; i < 4; i++) begin
            protect_region_field_i <= 2'(i);
            wr(nwg_pkg::IDX_CONTROL, 8'h84);
            go(8'h86);
            rchk(nwg_pkg::IDX_CONTROL, 8'h84);
            if (i >= 2) n0++;
            chk(m.wr_count, n0);
        end
        rchk(nwg_pkg::IDX_IRQ_FLAGS, 8'h00);
        // external grants for every protect and target combination
        ext_rd_req_i <= 1'b1;
        ext_wr_req_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            {cp_data_i, cp_pgm_i, ext_pgm_i} <= 3'(i);
            repeat (5) @(posedge clk_i);
            chk({31'h0, ext_rd_grant_o}, {31'h0, ext_pgm_i ? !cp_pgm_i : !cp_data_i});
            chk({31'h0, ext_wr_grant_o},
                {31'h0, ext_pgm_i ? !(cp_pgm_i | cp_data_i) : !cp_data_i});
        end
        // reset in mid-run keeps data registers and clears the latch
        wr(nwg_pkg::IDX_DATA_LOW, 8'ha5);
        wr(nwg_pkg::IDX_CONTROL, 8'h04);
        go(8'h06);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(nwg_pkg::IDX_DATA_LOW, 8'ha5);
        rchk(nwg_pkg::IDX_CONTROL, 8'h08);
        test_done();
    end
endmodule
